// *** core/paired_timer_32bit.v ***
`timescale 1ns/1ns
`include "timer_pair_consts.vh"
module paired_timer_32bit #(
  parameter HAS_ADC_TRIGGER = 1
) (
  input  wire        SYS_CLK_I,
  input  wire        RESET_I,
  input  wire        IDLE_I,
  input  wire        LOW_TIMER_ON_I,
  input  wire        LOW_STOP_IN_IDLE_I,
  input  wire [1:0]  LOW_PRESCALE_SELECT_I,
  input  wire        LOW_CLOCK_SOURCE_SELECT_I,
  input  wire        LOW_GATE_MODE_I,
  input  wire        PAIR_ENABLE_I,
  input  wire        HIGH_TIMER_ON_I,
  input  wire        HIGH_STOP_IN_IDLE_I,
  input  wire [1:0]  HIGH_PRESCALE_SELECT_I,
  input  wire        HIGH_CLOCK_SOURCE_SELECT_I,
  input  wire        HIGH_GATE_MODE_I,
  input  wire        LOW_EXT_CLK_I,
  input  wire        LOW_GATE_I,
  input  wire        HIGH_EXT_CLK_I,
  input  wire        HIGH_GATE_I,
  input  wire [15:0] PERIOD_LOW_I,
  input  wire [15:0] PERIOD_HIGH_I,
  input  wire        COUNT_LOW_WR_I,
  input  wire        COUNT_HIGH_WR_I,
  input  wire [15:0] COUNT_WDATA_I,
  input  wire        LOW_FLAG_CLR_I,
  input  wire        HIGH_FLAG_CLR_I,
  output wire [15:0] COUNT_LOW_O,
  output wire [15:0] COUNT_HIGH_O,
  output wire        LOW_FLAG_O,
  output wire        HIGH_FLAG_O,
  output wire        ADC_TRIGGER_O
);
  reg  [`TMR_WORD_W-1:0] count_low_ff;
  reg  [`TMR_WORD_W-1:0] count_high_ff;
  reg  [`TMR_WORD_W-1:0] nxt_count_low;
  reg  [`TMR_WORD_W-1:0] nxt_count_high;
  reg                    low_flag_ff;
  reg                    high_flag_ff;
  reg                    adc_trig_ff;
  reg                    low_match;
  reg                    high_match;
  reg                    pair_match;

  wire                   low_ext_lvl;
  wire                   low_ext_rise;
  wire                   low_gate_lvl;
  wire                   high_ext_lvl;
  wire                   high_ext_rise;
  wire                   high_gate_lvl;
  wire                   low_run;
  wire                   high_run;
  wire                   low_tick;
  wire                   high_tick;
  wire [`TMR_PAIR_W-1:0] count_pair;
  wire [`TMR_PAIR_W-1:0] period_pair;
  wire [`TMR_PAIR_W-1:0] count_pair_inc;

  // every pin that feeds the counters is resynchronised first
  pin_sync3 u_low_clk_sync (
    .clk_i   (SYS_CLK_I),
    .rst_i   (RESET_I),
    .pin_i   (LOW_EXT_CLK_I),
    .level_o (low_ext_lvl),
    .rise_o  (low_ext_rise)
  );

  pin_sync3 u_low_gate_sync (
    .clk_i   (SYS_CLK_I),
    .rst_i   (RESET_I),
    .pin_i   (LOW_GATE_I),
    .level_o (low_gate_lvl),
    .rise_o  ()
  );

  pin_sync3 u_high_clk_sync (
    .clk_i   (SYS_CLK_I),
    .rst_i   (RESET_I),
    .pin_i   (HIGH_EXT_CLK_I),
    .level_o (high_ext_lvl),
    .rise_o  (high_ext_rise)
  );

  pin_sync3 u_high_gate_sync (
    .clk_i   (SYS_CLK_I),
    .rst_i   (RESET_I),
    .pin_i   (HIGH_GATE_I),
    .level_o (high_gate_lvl),
    .rise_o  ()
  );

  // timer_on is the final enable; nothing here latches setup on it
  assign low_run  = LOW_TIMER_ON_I &
                    ~(IDLE_I & LOW_STOP_IN_IDLE_I);
  // paired: the upper control bits have no effect at all
  assign high_run = ~PAIR_ENABLE_I & HIGH_TIMER_ON_I &
                    ~(IDLE_I & HIGH_STOP_IN_IDLE_I);

  // lower tick source drives the whole 32-bit counter when paired
  tick_gen u_low_tick (
    .clk_i                 (SYS_CLK_I),
    .rst_i                 (RESET_I),
    .run_i                 (low_run),
    .prescale_select_i     (LOW_PRESCALE_SELECT_I),
    .clock_source_select_i (LOW_CLOCK_SOURCE_SELECT_I),
    .gate_mode_i           (LOW_GATE_MODE_I),
    .ext_rise_i            (low_ext_rise),
    .gate_level_i          (low_gate_lvl),
    .tick_o                (low_tick)
  );

  tick_gen u_high_tick (
    .clk_i                 (SYS_CLK_I),
    .rst_i                 (RESET_I),
    .run_i                 (high_run),
    .prescale_select_i     (HIGH_PRESCALE_SELECT_I),
    .clock_source_select_i (HIGH_CLOCK_SOURCE_SELECT_I),
    .gate_mode_i           (HIGH_GATE_MODE_I),
    .ext_rise_i            (high_ext_rise),
    .gate_level_i          (high_gate_lvl),
    .tick_o                (high_tick)
  );

  assign count_pair     = {count_high_ff, count_low_ff};
  assign period_pair    = {PERIOD_HIGH_I, PERIOD_LOW_I};
  assign count_pair_inc = count_pair + 32'h00000001;

  always @* begin
    nxt_count_low  = count_low_ff;
    nxt_count_high = count_high_ff;
    low_match      = 1'b0;
    high_match     = 1'b0;
    pair_match     = 1'b0;
    if (PAIR_ENABLE_I) begin
      if (low_tick) begin
        if (count_pair == period_pair) begin
          pair_match     = 1'b1;
          nxt_count_low  = `TMR_COUNT_RST;
          nxt_count_high = `TMR_COUNT_RST;
        end else begin
          nxt_count_low  = count_pair_inc[15:0];
          nxt_count_high = count_pair_inc[31:16];
        end
      end
    end else begin
      if (low_tick) begin
        if (count_low_ff == PERIOD_LOW_I) begin
          low_match     = 1'b1;
          nxt_count_low = `TMR_COUNT_RST;
        end else begin
          nxt_count_low = count_low_ff + 16'h0001;
        end
      end
      if (high_tick) begin
        if (count_high_ff == PERIOD_HIGH_I) begin
          high_match     = 1'b1;
          nxt_count_high = `TMR_COUNT_RST;
        end else begin
          nxt_count_high = count_high_ff + 16'h0001;
        end
      end
    end
    // a software write overrides the tick in the same cycle
    if (COUNT_LOW_WR_I) begin
      nxt_count_low = COUNT_WDATA_I;
    end
    if (COUNT_HIGH_WR_I) begin
      nxt_count_high = COUNT_WDATA_I;
    end
  end

  always @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      count_low_ff  <= `TMR_COUNT_RST;
      count_high_ff <= `TMR_COUNT_RST;
      low_flag_ff   <= 1'b0;
      high_flag_ff  <= 1'b0;
      adc_trig_ff   <= 1'b0;
    end else begin
      count_low_ff  <= nxt_count_low;
      count_high_ff <= nxt_count_high;
      // set wins over a clear arriving in the same cycle
      low_flag_ff   <= low_match | (low_flag_ff & ~LOW_FLAG_CLR_I);
      high_flag_ff  <= high_match | pair_match |
                       (high_flag_ff & ~HIGH_FLAG_CLR_I);
      // upper timer event is the trigger source, paired or not
      adc_trig_ff   <= (HAS_ADC_TRIGGER != 0) &
                       (high_match | pair_match);
    end
  end

  assign COUNT_LOW_O   = count_low_ff;
  assign COUNT_HIGH_O  = count_high_ff;
  assign LOW_FLAG_O    = low_flag_ff;
  assign HIGH_FLAG_O   = high_flag_ff;
  assign ADC_TRIGGER_O = adc_trig_ff;
endmodule

// *** core/pin_sync3.v ***
`timescale 1ns/1ns
`include "timer_pair_consts.vh"
module pin_sync3 (
  input  wire clk_i,
  input  wire rst_i,
  input  wire pin_i,
  output wire level_o,
  output wire rise_o
);
  reg meta_ff;
  reg sync2_ff;
  reg sync3_ff;
  reg level_ff;
  reg rise_ff;

  // a change counts only once stages two and three agree
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff  <= 1'b0;
      sync2_ff <= 1'b0;
      sync3_ff <= 1'b0;
      level_ff <= 1'b0;
      rise_ff  <= 1'b0;
    end else begin
      meta_ff  <= pin_i;
      sync2_ff <= meta_ff;
      sync3_ff <= sync2_ff;
      rise_ff  <= 1'b0;
      if (sync2_ff == sync3_ff) begin
        level_ff <= sync3_ff;
        rise_ff  <= sync3_ff & ~level_ff;
      end
    end
  end

  assign level_o = level_ff;
  assign rise_o  = rise_ff;
endmodule

// *** core/tick_gen.v ***
`timescale 1ns/1ns
`include "timer_pair_consts.vh"
module tick_gen (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       run_i,
  input  wire [1:0] prescale_select_i,
  input  wire       clock_source_select_i,
  input  wire       gate_mode_i,
  input  wire       ext_rise_i,
  input  wire       gate_level_i,
  output wire       tick_o
);
  reg  [`TMR_PSC_W-1:0] psc_ff;
  reg  [`TMR_PSC_W-1:0] nxt_psc;
  reg                   nxt_tick;
  wire                  event_in;

  function [`TMR_PSC_W-1:0] psc_terminal;
    input [`TMR_PSC_SEL_W-1:0] sel;
    begin
      case (sel)
        `TMR_PSC_DIV1:  psc_terminal = `TMR_PSC_TC1;
        `TMR_PSC_DIV8:  psc_terminal = `TMR_PSC_TC8;
        `TMR_PSC_DIV64: psc_terminal = `TMR_PSC_TC64;
        default:        psc_terminal = `TMR_PSC_TC256;
      endcase
    end
  endfunction

  // gate only qualifies the internal clock; ext pulses ignore it
  assign event_in = clock_source_select_i ? ext_rise_i :
                    (gate_mode_i ? gate_level_i : 1'b1);

  always @* begin
    nxt_psc  = psc_ff;
    nxt_tick = 1'b0;
    if (!run_i) begin
      nxt_psc = {`TMR_PSC_W{1'b0}};
    end else if (event_in) begin
      if (psc_ff >= psc_terminal(prescale_select_i)) begin
        nxt_psc  = {`TMR_PSC_W{1'b0}};
        nxt_tick = 1'b1;
      end else begin
        nxt_psc = psc_ff + 8'h01;
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      psc_ff <= {`TMR_PSC_W{1'b0}};
    end else begin
      psc_ff <= nxt_psc;
    end
  end

  // combinational strobe, one cycle wide, keeps the count one cycle closer
  assign tick_o = nxt_tick;
endmodule

// *** core/timer_pair_consts.vh ***
// Summary of operation
// - pair enable joins both timers into 32
// - lower timer is low word, upper high
// - paired: upper control bits are ignored
// - paired: lower clock/gate drive, upper flag
// - 32-bit period is period_high:period_low
// - count_high holds msw, count_low holds lsw
// - only first pair upper gives A/D trigger
// - two 16-bit, 32-bit timer, 32-bit counter
// - 32-bit count match period raises event
// - unpaired: each matches its own period
// - prescale field, clock source, gate bits
// - gated counting, prescaling, idle counting
// - each timer: internal timer or ext counter
`ifndef TIMER_PAIR_CONSTS_VH
`define TIMER_PAIR_CONSTS_VH

`define TMR_WORD_W        16
`define TMR_PAIR_W        32
`define TMR_PSC_W         8
`define TMR_PSC_SEL_W     2

// prescale_select codes and their terminal counts (ratio - 1)
`define TMR_PSC_DIV1      2'h0
`define TMR_PSC_DIV8      2'h1
`define TMR_PSC_DIV64     2'h2
`define TMR_PSC_DIV256    2'h3
`define TMR_PSC_TC1       8'h00
`define TMR_PSC_TC8       8'h07
`define TMR_PSC_TC64      8'h3F
`define TMR_PSC_TC256     8'hFF

`define TMR_COUNT_RST     16'h0000
`define TMR_PERIOD_RST    16'hFFFF

`endif

// *** dv/paired_timer_32bit_bench.sv ***
`timescale 1ns/1ns
`define CHK(nm, exp, got) \
  n_tests = n_tests + 1; \
  if ((got) !== (exp)) begin \
    n_errors = n_errors + 1; \
    $display("mismatch %s expected %h seen %h", nm, exp, got); \
  end
module paired_timer_32bit_bench;
  reg clk, rst, idle, pair, on_l, on_h, stop_l, stop_h, src_l, src_h;
  reg gm_l, gm_h, ext_l, ext_h, gate_l, gate_h, wr_l, wr_h, clr_l, clr_h;
  reg [1:0] psc_l, psc_h;
  reg [15:0] per_l, per_h, wdata, a;
  wire [15:0] cnt_l, cnt_h;
  wire flag_l, flag_h, adc;
  wire [15:0] cnt_l0, cnt_h0;
  wire flag_l0, flag_h0, adc0;
  integer n_errors, n_tests, n_adc, k;
  paired_timer_32bit #(.HAS_ADC_TRIGGER(1)) dut (
    .SYS_CLK_I(clk), .RESET_I(rst), .IDLE_I(idle), .PAIR_ENABLE_I(pair),
    .LOW_TIMER_ON_I(on_l), .LOW_STOP_IN_IDLE_I(stop_l),
    .LOW_PRESCALE_SELECT_I(psc_l), .LOW_CLOCK_SOURCE_SELECT_I(src_l),
    .LOW_GATE_MODE_I(gm_l), .HIGH_TIMER_ON_I(on_h),
    .HIGH_STOP_IN_IDLE_I(stop_h), .HIGH_PRESCALE_SELECT_I(psc_h),
    .HIGH_CLOCK_SOURCE_SELECT_I(src_h), .HIGH_GATE_MODE_I(gm_h),
    .LOW_EXT_CLK_I(ext_l), .LOW_GATE_I(gate_l), .HIGH_EXT_CLK_I(ext_h),
    .HIGH_GATE_I(gate_h), .PERIOD_LOW_I(per_l), .PERIOD_HIGH_I(per_h),
    .COUNT_LOW_WR_I(wr_l), .COUNT_HIGH_WR_I(wr_h), .COUNT_WDATA_I(wdata),
    .LOW_FLAG_CLR_I(clr_l), .HIGH_FLAG_CLR_I(clr_h), .COUNT_LOW_O(cnt_l),
    .COUNT_HIGH_O(cnt_h), .LOW_FLAG_O(flag_l), .HIGH_FLAG_O(flag_h),
    .ADC_TRIGGER_O(adc)
  );
  // a pair without trigger hardware sees the same stimulus
  paired_timer_32bit #(.HAS_ADC_TRIGGER(0)) no_trig (
    .SYS_CLK_I(clk), .RESET_I(rst), .IDLE_I(idle), .PAIR_ENABLE_I(pair),
    .LOW_TIMER_ON_I(on_l), .LOW_STOP_IN_IDLE_I(stop_l),
    .LOW_PRESCALE_SELECT_I(psc_l), .LOW_CLOCK_SOURCE_SELECT_I(src_l),
    .LOW_GATE_MODE_I(gm_l), .HIGH_TIMER_ON_I(on_h),
    .HIGH_STOP_IN_IDLE_I(stop_h), .HIGH_PRESCALE_SELECT_I(psc_h),
    .HIGH_CLOCK_SOURCE_SELECT_I(src_h), .HIGH_GATE_MODE_I(gm_h),
    .LOW_EXT_CLK_I(ext_l), .LOW_GATE_I(gate_l), .HIGH_EXT_CLK_I(ext_h),
    .HIGH_GATE_I(gate_h), .PERIOD_LOW_I(per_l), .PERIOD_HIGH_I(per_h),
    .COUNT_LOW_WR_I(wr_l), .COUNT_HIGH_WR_I(wr_h), .COUNT_WDATA_I(wdata),
    .LOW_FLAG_CLR_I(clr_l), .HIGH_FLAG_CLR_I(clr_h), .COUNT_LOW_O(cnt_l0),
    .COUNT_HIGH_O(cnt_h0), .LOW_FLAG_O(flag_l0), .HIGH_FLAG_O(flag_h0),
    .ADC_TRIGGER_O(adc0)
  );
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (adc === 1'b1) n_adc = n_adc + 1;
  task cyc(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task wr(input hi, input [15:0] v);
    begin
      wdata = v;
      wr_l = !hi;
      wr_h = hi;
      cyc(1);
      wr_l = 1'b0;
      wr_h = 1'b0;
    end
  endtask
  task clr;
    begin
      clr_l = 1'b1;
      clr_h = 1'b1;
      cyc(1);
      clr_l = 1'b0;
      clr_h = 1'b0;
    end
  endtask
  task end_sim;
    begin
      if (n_errors == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    n_errors = n_errors + 1;
    end_sim;
  end
  initial begin
    {rst, idle, pair, on_l, on_h, stop_l, stop_h, src_l, src_h} = 9'h100;
    {gm_l, gm_h, ext_l, ext_h, gate_l, gate_h, wr_l, wr_h, clr_l} = 9'h0;
    {clr_h, psc_l, psc_h, per_l, per_h, wdata} = 53'h0;
    {n_errors, n_tests, n_adc} = 0;
    cyc(20);
    rst = 1'b0;
    `CHK("reset count", 32'h0, {cnt_h, cnt_l})
    per_l = 16'h0002;
    on_l = 1'b1;
    cyc(2);
    `CHK("low count", 16'h0002, cnt_l)
    cyc(1);
    `CHK("low wrap", 17'h10000, {flag_l, cnt_l})
    `CHK("high flag", 1'b0, flag_h)
    on_l = 1'b0;
    per_h = 16'hFFFF;
    on_h = 1'b1;
    // codes rise so a stale prescale count never exceeds the new ratio
    for (k = 0; k < 4; k = k + 1) begin
      psc_h = k;
      cyc(k == 3 ? 256 : 1 << (3 * k));
      a = cnt_h;
      cyc(k == 3 ? 256 : 1 << (3 * k));
      `CHK("prescale tick", 16'h0001, cnt_h - a)
    end
    on_h = 1'b0;
    psc_h = 2'h0;
    wr(1'b1, 16'h0000);
    clr;
    per_h = 16'h0001;
    k = n_adc;
    on_h = 1'b1;
    cyc(2);
    on_h = 1'b0;
    `CHK("high wrap", 17'h10000, {flag_h, cnt_h})
    // the pulse stands one cycle; the edge counter sees it one edge later
    `CHK("trigger", 1'b1, adc)
    `CHK("no trigger", 1'b0, adc0)
    clr;
    `CHK("trigger count", k + 1, n_adc)
    `CHK("flag clear", 1'b0, flag_h)
    pair = 1'b1;
    psc_h = 2'h3;
    on_h = 1'b1;
    per_l = 16'h0001;
    wr(1'b0, 16'hFFFE);
    k = n_adc;
    on_l = 1'b1;
    cyc(2);
    `CHK("carry", 32'h00010000, {cnt_h, cnt_l})
    cyc(2);
    `CHK("32 match", 32'h0, {cnt_h, cnt_l})
    `CHK("32 flags", 2'h2, {flag_h, flag_l})
    `CHK("32 trigger", 1'b1, adc)
    `CHK("32 no trigger", 1'b0, adc0)
    on_l = 1'b0;
    per_l = 16'hFFFF;
    per_h = 16'hFFFF;
    wr(1'b0, 16'h0000);
    `CHK("32 trigger count", k + 1, n_adc)
    src_l = 1'b1;
    src_h = 1'b1;
    on_l = 1'b1;
    // upper pin toggles too; paired mode must ignore it
    repeat (3) begin
      {ext_l, ext_h} = 2'h3;
      cyc(4);
      {ext_l, ext_h} = 2'h0;
      cyc(4);
    end
    cyc(6);
    `CHK("ext count", 32'h00000003, {cnt_h, cnt_l})
    on_l = 1'b0;
    pair = 1'b0;
    src_l = 1'b0;
    gm_l = 1'b1;
    wr(1'b0, 16'h0000);
    on_l = 1'b1;
    cyc(10);
    `CHK("gate closed", 16'h0000, cnt_l)
    {gate_l, gate_h, gm_h} = 3'h7;
    cyc(8);
    a = cnt_l;
    idle = 1'b1;
    cyc(5);
    `CHK("gate open idle", 16'h0005, cnt_l - a)
    {stop_l, stop_h} = 2'h3;
    cyc(2);
    a = cnt_l;
    cyc(5);
    `CHK("idle stop", 16'h0000, cnt_l - a)
    end_sim;
  end
endmodule
bind paired_timer_32bit paired_timer_32bit_props #(
  .HAS_ADC_TRIGGER(HAS_ADC_TRIGGER)
) u_props (.*);

// *** dv/paired_timer_32bit_props.sv ***
`timescale 1ns/1ns
module paired_timer_32bit_props #(
  parameter HAS_ADC_TRIGGER = 1
) (
  input wire logic        SYS_CLK_I,
  input wire logic        RESET_I,
  input wire logic        IDLE_I,
  input wire logic        PAIR_ENABLE_I,
  input wire logic        LOW_TIMER_ON_I,
  input wire logic        LOW_STOP_IN_IDLE_I,
  input wire logic [1:0]  LOW_PRESCALE_SELECT_I,
  input wire logic        LOW_CLOCK_SOURCE_SELECT_I,
  input wire logic        LOW_GATE_MODE_I,
  input wire logic [15:0] PERIOD_LOW_I,
  input wire logic [15:0] PERIOD_HIGH_I,
  input wire logic [15:0] COUNT_WDATA_I,
  input wire logic        COUNT_LOW_WR_I,
  input wire logic        COUNT_HIGH_WR_I,
  input wire logic        HIGH_FLAG_CLR_I,
  input wire logic [15:0] COUNT_LOW_O,
  input wire logic [15:0] COUNT_HIGH_O,
  input wire logic        LOW_FLAG_O,
  input wire logic        HIGH_FLAG_O,
  input wire logic        ADC_TRIGGER_O
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RESET_I);
  // fast: a tick on every edge, so the next edge shows the result
  wire held = !LOW_TIMER_ON_I || (LOW_STOP_IN_IDLE_I && IDLE_I);
  wire fast = !held && LOW_PRESCALE_SELECT_I == 2'h0 &&
              !LOW_CLOCK_SOURCE_SELECT_I && !LOW_GATE_MODE_I;
  wire no_wr = !COUNT_LOW_WR_I && !COUNT_HIGH_WR_I;
  wire pmatch = {COUNT_HIGH_O, COUNT_LOW_O} == {PERIOD_HIGH_I, PERIOD_LOW_I};
  sequence s_pair_run;
    PAIR_ENABLE_I && fast && no_wr;
  endsequence
  sequence s_zero;
    COUNT_LOW_O == 16'h0000 && COUNT_HIGH_O == 16'h0000;
  endsequence
  property p_pair_match;
    s_pair_run ##0 pmatch |=> s_zero ##0 HIGH_FLAG_O;
  endproperty
  a_pair_match: assert property (p_pair_match)
    else $error("paired match did not wrap and flag");
  property p_carry;
    s_pair_run ##0 (COUNT_LOW_O == 16'hFFFF && !pmatch) |=> COUNT_LOW_O ==
      16'h0000 && COUNT_HIGH_O == $past(COUNT_HIGH_O) + 16'h0001;
  endproperty
  a_carry: assert property (p_carry)
    else $error("low word wrap did not carry");
  property p_low_wrap;
    !PAIR_ENABLE_I && fast && no_wr && COUNT_LOW_O == PERIOD_LOW_I
      |=> COUNT_LOW_O == 16'h0000 && LOW_FLAG_O;
  endproperty
  a_low_wrap: assert property (p_low_wrap)
    else $error("lower timer did not wrap at its period");
  property p_pair_low_quiet;
    PAIR_ENABLE_I && !LOW_FLAG_O |=> !LOW_FLAG_O;
  endproperty
  a_pair_low_quiet: assert property (p_pair_low_quiet)
    else $error("lower flag set in paired mode");
  property p_held_low;
    held && !COUNT_LOW_WR_I |=> $stable(COUNT_LOW_O);
  endproperty
  a_held_low: assert property (p_held_low)
    else $error("lower count moved while stopped");
  property p_held_high;
    PAIR_ENABLE_I && held && !COUNT_HIGH_WR_I |=> $stable(COUNT_HIGH_O);
  endproperty
  a_held_high: assert property (p_held_high)
    else $error("upper count moved while paired timer stopped");
  property p_wr_low;
    COUNT_LOW_WR_I |=> COUNT_LOW_O == $past(COUNT_WDATA_I);
  endproperty
  a_wr_low: assert property (p_wr_low)
    else $error("lower count write lost");
  property p_wr_high;
    COUNT_HIGH_WR_I |=> COUNT_HIGH_O == $past(COUNT_WDATA_I);
  endproperty
  a_wr_high: assert property (p_wr_high)
    else $error("upper count write lost");
  property p_adc_flag;
    ADC_TRIGGER_O |-> HIGH_FLAG_O && HAS_ADC_TRIGGER != 0;
  endproperty
  a_adc_flag: assert property (p_adc_flag)
    else $error("trigger without upper match");
  property p_flag_hold;
    HIGH_FLAG_O && !HIGH_FLAG_CLR_I |=> HIGH_FLAG_O;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("upper flag dropped without clear");
endmodule
